// >>> hdl/csso_pkg.sv
// package: register map, field positions, encodings and timing for clock control
`default_nettype none
package csso_pkg;
    localparam logic [7:0] TUNE_ADDR = 8'h96;
    localparam logic [7:0] CONFIG_ADDR = 8'hA0;
    localparam logic [7:0] DIVIDER_ADDR = 8'hA1;
    localparam logic [7:0] AUX_ADDR = 8'hA2;
    localparam logic [7:0] STATUS_ADDR = 8'hA3;
    localparam int TUNE_EN_BIT = 6;
    localparam int TUNE_W = 6;
    localparam logic [5:0] TUNE_FACTORY = 6'h20;
    localparam int LP_BIT = 7;
    localparam logic [2:0] SRC_XTAL_LOW = 3'h0;
    localparam logic [2:0] SRC_XTAL_MED = 3'h1;
    localparam logic [2:0] SRC_XTAL_HIGH = 3'h2;
    localparam logic [2:0] SRC_RC = 3'h3;
    localparam logic [2:0] SRC_WDOG = 3'h4;
    localparam logic [2:0] SRC_EXT = 3'h7;
    localparam logic [1:0] RTC_XTAL_LOW = 2'h0;
    localparam logic [1:0] RTC_XTAL_MED = 2'h1;
    localparam logic [1:0] RTC_XTAL_HIGH = 2'h2;
    localparam logic [1:0] RTC_INTERNAL = 2'h3;
    localparam logic [1:0] OPT_LOW = 2'h0;
    localparam logic [1:0] OPT_MED = 2'h1;
    localparam logic [1:0] OPT_HIGH = 2'h2;
    localparam logic [1:0] OPT_NONE = 2'h3;
    localparam int CPU_CLK_MAX_LP_HZ = 8000000;
endpackage : csso_pkg
`default_nettype wire

// >>> hdl/csso_top.sv
// clock source select, cpu divider, peripheral clock and clock output pin
//
// The strobed register port was decided locally.
`default_nettype none
// Overview of operation
// - machine cycle strobe every two cpu clock cycles
// - peripheral clock enable runs at half the cpu clock rate
// - exactly one source feeds the cpu clock divider
// - source is chosen by nonvolatile config bits, fixed at programming
// - rc or watchdog source lets rtc field choose crystal option
// - low, medium and high crystal options are supported
// - clock pin driven only if enabled, no crystal, rtc not on crystal
// - clock pin toggles once per cpu clock, so it runs at half the cpu clock rate
// - enable cleared means no clock appears on the pin
// - six bit tuning field, larger value means lower rc frequency
// - only power on reset loads factory tuning and clears enable
// - low power select bit cleared on every reset
// - cpu clock is osc clock over twice divider, zero passes
module csso_top
    import csso_pkg::*;
#(
    parameter logic [5:0] TUNE_RESET = TUNE_FACTORY
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic por,
    input wire logic [2:0] osc_source_select,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic port_pin_out,
    output logic [7:0] rdata,
    output logic [2:0] osc_sel_onehot,
    output logic [1:0] crystal_option,
    output logic cpu_clock_en,
    output logic machine_cycle_en,
    output logic periph_clock_en,
    output logic [5:0] rc_tune,
    output logic low_power_clock_select,
    output logic clock_output_pin
);
    typedef struct packed {
        logic [2:0] src;
        logic src_valid;
        logic [1:0] rtc_opt;
        logic [7:0] div;
        logic [8:0] cnt; // nine bits: reload reaches 2*255-1
        logic cpu_en;
        logic phase;
        logic mc_en;
        logic pc_en;
        logic [5:0] tune;
        logic out_en;
        logic lp;
        logic [2:0] onehot;
        logic [1:0] xopt;
        logic pin;
        logic pin_sel;
        logic [7:0] rdata;
    } csso_state_t;

    csso_state_t s_q;
    csso_state_t s_d;
    logic is_internal;
    logic xtal_in_use;
    logic rtc_on_xtal;
    logic clk_out_ok;

    // rc and watchdog sources hand the crystal option to the rtc field
    always_comb
    begin
        is_internal = (s_q.src == SRC_RC) || (s_q.src == SRC_WDOG);
        rtc_on_xtal = (s_q.rtc_opt != RTC_INTERNAL);
        xtal_in_use = !is_internal && (s_q.src != SRC_EXT);
        clk_out_ok = s_q.out_en && !xtal_in_use && !rtc_on_xtal;
    end

    always_comb
    begin
        s_d = s_q;
        // config bits are latched once after reset release, never live
        if (!s_q.src_valid)
        begin
            s_d.src = osc_source_select;
            s_d.src_valid = 1'b1;
        end
        // one-hot select: watchdog, rc, crystal/external
        s_d.onehot = 3'h0;
        if (s_q.src == SRC_WDOG)
            s_d.onehot = 3'h1;
        else if (s_q.src == SRC_RC)
            s_d.onehot = 3'h2;
        else
            s_d.onehot = 3'h4;
        // crystal option choice
        if (is_internal)
            s_d.xopt = s_q.rtc_opt;
        else if (s_q.src == SRC_XTAL_LOW)
            s_d.xopt = OPT_LOW;
        else if (s_q.src == SRC_XTAL_MED)
            s_d.xopt = OPT_MED;
        else if (s_q.src == SRC_XTAL_HIGH)
            s_d.xopt = OPT_HIGH;
        else
            s_d.xopt = OPT_NONE;
        // divide by 2n: one enable pulse every 2n osc clocks, 0 bypasses
        // the pulse cycle itself counts, so the reload is 2n-1, not 2n
        // a nonzero divider change only takes hold at the next reload, so the
        // cpu clock never sees a short period when software retunes it
        s_d.cpu_en = 1'b0;
        if (s_q.div == 8'h00)
        begin
            s_d.cpu_en = 1'b1;
            s_d.cnt = 9'h000;
        end
        else if (s_q.cnt == 9'h000)
        begin
            s_d.cpu_en = 1'b1;
            s_d.cnt = ({1'b0, s_q.div} << 1) - 9'h001;
        end
        else
            s_d.cnt = s_q.cnt - 9'h001;
        // second-half cpu cycle closes a machine cycle and a pclk period
        s_d.mc_en = 1'b0;
        s_d.pc_en = 1'b0;
        if (s_d.cpu_en)
        begin
            s_d.phase = !s_q.phase;
            s_d.mc_en = s_q.phase;
            s_d.pc_en = s_q.phase;
        end
        // pin: toggle per cpu clock gives cpu_clock/2; leave only when low
        if (clk_out_ok && s_d.cpu_en)
            s_d.pin = !s_q.pin;
        if (clk_out_ok)
            s_d.pin_sel = 1'b1;
        else if (!s_q.pin || !s_q.pin_sel)
        begin
            s_d.pin_sel = 1'b0;
            s_d.pin = 1'b0;
        end
        else if (s_d.cpu_en)
            s_d.pin = 1'b0; // finish the high half before handing back
        // register writes; tune write keeps whatever software sends
        if (wr_en)
        begin
            unique case (addr)
                TUNE_ADDR:
                begin
                    s_d.tune = wdata[TUNE_W-1:0];
                    s_d.out_en = wdata[TUNE_EN_BIT];
                end
                CONFIG_ADDR: s_d.rtc_opt = wdata[1:0];
                DIVIDER_ADDR: s_d.div = wdata;
                AUX_ADDR: s_d.lp = wdata[LP_BIT];
                default: ;
            endcase
        end
        s_d.rdata = 8'h00;
        if (rd_en)
        begin
            unique case (addr)
                TUNE_ADDR: s_d.rdata = {1'b0, s_q.out_en, s_q.tune};
                CONFIG_ADDR: s_d.rdata = {6'h00, s_q.rtc_opt};
                DIVIDER_ADDR: s_d.rdata = s_q.div;
                AUX_ADDR: s_d.rdata = {s_q.lp, 7'h00};
                STATUS_ADDR: s_d.rdata = {s_q.pin_sel, s_q.xopt,
                    s_q.onehot, s_q.phase, s_q.src_valid};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_q.src <= SRC_RC;
            s_q.src_valid <= 1'b0;
            s_q.rtc_opt <= RTC_INTERNAL;
            s_q.div <= 8'h00;
            s_q.cnt <= 9'h000;
            s_q.cpu_en <= 1'b0;
            s_q.phase <= 1'b0;
            s_q.mc_en <= 1'b0;
            s_q.pc_en <= 1'b0;
            s_q.lp <= 1'b0;
            s_q.onehot <= 3'h2;
            s_q.xopt <= OPT_NONE;
            s_q.pin <= 1'b0;
            s_q.pin_sel <= 1'b0;
            s_q.rdata <= 8'h00;
            if (por)
            begin
                s_q.tune <= TUNE_RESET;
                s_q.out_en <= 1'b0;
            end
            else
            begin
                s_q.tune <= s_d.tune;
                s_q.out_en <= s_d.out_en;
            end
        end
        else
            s_q <= s_d;
    end

    assign rdata = s_q.rdata;
    assign osc_sel_onehot = s_q.onehot;
    assign crystal_option = s_q.xopt;
    assign cpu_clock_en = s_q.cpu_en;
    assign machine_cycle_en = s_q.mc_en;
    assign periph_clock_en = s_q.pc_en;
    assign rc_tune = s_q.tune;
    assign low_power_clock_select = s_q.lp;
    // pin flop is forced low whenever the select is low, so it can feed
    // the pin directly; the port mux outside switches only with pin low
    assign clock_output_pin = s_q.pin;

    AST_ONEHOT: assert property (@(posedge clk_sys) disable iff (rst)
        $onehot(s_q.onehot)) else $error("select not one-hot");
    AST_SRC_FIXED: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.src_valid |=> $stable(s_q.src))
        else $error("source changed");
    AST_MC_PAIR: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.mc_en |-> s_q.cpu_en && !s_q.phase)
        else $error("machine cycle misaligned");
    AST_PCLK: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.pc_en == s_q.mc_en) else $error("pclk rate");
    AST_BYPASS: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.div == 8'h00) [*2] |=> s_q.cpu_en)
        else $error("bypass lost");
    AST_DIV1: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.cpu_en && s_q.div == 8'h01 && $stable(s_q.div))
        |=> !s_q.cpu_en ##1 s_q.cpu_en) else $error("div2 wrong");
    AST_NO_OUT: assert property (@(posedge clk_sys) disable iff (rst)
        (!clk_out_ok [*3]) |-> !s_q.pin || !s_q.pin_sel ||
        $past(s_q.pin) == 1'b0) else $error("pin clocking");
    AST_XOPT: assert property (@(posedge clk_sys) disable iff (rst)
        (is_internal && $stable(s_q.rtc_opt)) |=> s_q.xopt == $past(s_q.rtc_opt))
        else $error("rtc option ignored");
    AST_LP: assert property (@(posedge clk_sys)
        $past(rst) |-> !s_q.lp) else $error("lp not cleared");
    AST_TUNE_KEEP: assert property (@(posedge clk_sys)
        ($past(rst) && !$past(por) && !$past(wr_en)) |->
        $stable(s_q.tune)) else $error("tune lost");
    AST_PIN_TOG: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_out_ok && s_d.cpu_en) |=> s_q.pin != $past(s_q.pin))
        else $error("pin not toggling");

    // divide by four: three quiet cycles after every cpu clock pulse
    // a divider of zero written meanwhile bypasses, so it is excused
    AST_DIV2: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.cpu_en && s_q.div == 8'h02 && s_q.cnt == 9'h003)
        |=> (!s_q.cpu_en || s_q.div == 8'h00) [*3])
        else $error("div4 wrong");

    // the pin is only ever high while it is handed to the clock output
    AST_PIN_SEL: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.pin |-> s_q.pin_sel) else $error("pin high unselected");

    // once low and not allowed, the pin stays low: no stray edge
    AST_NO_PIN_OFF: assert property (@(posedge clk_sys) disable iff (rst)
        (!clk_out_ok && !s_q.pin) |=> !s_q.pin)
        else $error("pin rose while off");

    // power-on reset loads the factory trim and clears the enable
    AST_TUNE_POR: assert property (@(posedge clk_sys)
        ($past(rst) && $past(por)) |-> (s_q.tune == TUNE_RESET) &&
        !s_q.out_en) else $error("tune not loaded");

    // read data stand only in the cycle after a read strobe
    AST_RDATA_IDLE: assert property (@(posedge clk_sys)
        !$past(rd_en) |-> s_q.rdata == 8'h00)
        else $error("read data not idle");

    // divider writes land in the next cycle
    AST_WR_DIV: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_en && addr == DIVIDER_ADDR) |=> s_q.div == $past(wdata))
        else $error("divider write lost");

    // low power bit follows software once out of reset
    AST_LP_WR: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_en && addr == AUX_ADDR) |=> s_q.lp == $past(wdata[LP_BIT]))
        else $error("low power write lost");

    // a high speed crystal source always selects the high option
    AST_XOPT_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.src == SRC_XTAL_HIGH) |=> s_q.xopt == OPT_HIGH)
        else $error("crystal option wrong");

    // a crystal source never lets the clock output run
    AST_XTAL_NO_OUT: assert property (@(posedge clk_sys) disable iff (rst)
        xtal_in_use |-> !clk_out_ok)
        else $error("output with crystal");
endmodule : csso_top
`default_nettype wire

// >>> bench/csso_clk_watch.sv
// clock output consumer model: times the clock pin from rise to rise
`default_nettype none
module csso_clk_watch (
    input wire logic clk_sys,
    input wire logic pin,
    output logic [15:0] rise_cnt,
    output logic [15:0] period
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] since;
    logic last;
    // a consumer only sees edges, so a stuck pin shows as no new rises
    always @(posedge clk_sys)
    begin
        since <= since + 16'h1;
        last <= pin;
        if (pin && !last)
        begin
            rise_cnt <= rise_cnt + 16'h1;
            period <= since + 16'h1;
            since <= 16'h0;
        end
    end
    initial
    begin
        rise_cnt = 16'h0;
        period = 16'h0;
        since = 16'h0;
        last = 1'b0;
    end
endmodule : csso_clk_watch
`default_nettype wire

// >>> bench/clock_source_select_and_output_bench.sv
// testbench: register port tasks and clock rate checks
`default_nettype none
module clock_source_select_and_output_bench;
    import csso_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst = 1, por = 1, wr_en = 0, rd_en = 0;
    logic [2:0] src = 3'h3;
    logic [7:0] addr = 8'h0, wdata = 8'h0, rdata, rv;
    logic [2:0] onehot;
    logic [1:0] xopt;
    logic cpu_en, mc_en, pc_en, lp, pin;
    logic [5:0] tune;
    logic [15:0] rise_cnt, period, r0, cc, cm, cp, cr;
    int error_cnt = 0, compares = 0, cyc = 0;
    csso_top DUT (.clk_sys(clk_sys), .rst(rst), .por(por),
        .osc_source_select(src), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .port_pin_out(1'b0),
        .rdata(rdata), .osc_sel_onehot(onehot), .crystal_option(xopt),
        .cpu_clock_en(cpu_en), .machine_cycle_en(mc_en),
        .periph_clock_en(pc_en), .rc_tune(tune),
        .low_power_clock_select(lp), .clock_output_pin(pin));
    csso_clk_watch PEER (.clk_sys(clk_sys), .pin(pin),
        .rise_cnt(rise_cnt), .period(period));
    task tally_and_finish;
        $display("mismatches %0d of %0d compares", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task rst_dut(input logic p, input logic [2:0] s);
        @(posedge clk_sys);
        rst <= 1'b1;
        por <= p;
        src <= s;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : rst_dut
    // settle first so a divider change mid-phase is not counted
    task count(input int n);
        repeat (8) @(posedge clk_sys);
        cc = 16'h0;
        cm = 16'h0;
        cp = 16'h0;
        r0 = rise_cnt;
        repeat (n)
        begin
            @(posedge clk_sys);
            #1 cc = cc + cpu_en;
            cm = cm + mc_en;
            cp = cp + pc_en;
        end
        cr = rise_cnt - r0;
    endtask : count
    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end
    // hang guard, far above the length of the sequence
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            tally_and_finish;
        end
    end
    initial
    begin
        rst_dut(1'b1, SRC_RC);
        chk(onehot, 16'h2);
        chk(xopt, OPT_NONE);
        rd(TUNE_ADDR, rv);
        chk(rv, {2'h0, TUNE_FACTORY});
        rd(AUX_ADDR, rv);
        chk(rv, 16'h0);
        wr(8'h55, 8'hFF);
        rd(8'h55, rv);
        chk(rv, 16'h0);
        count(20);
        chk(cc, 16'h14);
        chk(cm, 16'hA);
        chk(cp, 16'hA);
        wr(DIVIDER_ADDR, 8'h02);
        count(40);
        chk(cc, 16'hA);
        chk(cm, 16'h5);
        chk(cp, 16'h5);
        rd(TUNE_ADDR, rv);
        wr(TUNE_ADDR, rv | 8'h40);
        count(80);
        chk(cr, 16'hA);
        chk(period, 16'h8);
        rd(TUNE_ADDR, rv);
        chk(rv, {2'h1, TUNE_FACTORY});
        wr(CONFIG_ADDR, {6'h0, RTC_XTAL_MED});
        count(80);
        chk(cr, 16'h0);
        chk(pin, 16'h0);
        chk(xopt, OPT_MED);
        wr(CONFIG_ADDR, {6'h0, RTC_INTERNAL});
        wr(AUX_ADDR, 8'h80);
        rd(AUX_ADDR, rv);
        chk(rv, 16'h80);
        wr(TUNE_ADDR, 8'h3F);
        count(40);
        chk(cr, 16'h0);
        chk(pin, 16'h0);
        rd(TUNE_ADDR, rv);
        chk(rv, 16'h3F);
        chk(tune, 16'h3F);
        wr(TUNE_ADDR, 8'hC5);
        for (int i = 0; i < 3; i++)
        begin
            rst_dut(1'b0, i[2:0]);
            chk(onehot, 16'h4);
            chk(xopt, i[1:0]);
            count(40);
            chk(cr, 16'h0);
        end
        rd(TUNE_ADDR, rv);
        chk(rv, 16'h45);
        rd(AUX_ADDR, rv);
        chk(rv, 16'h0);
        rst_dut(1'b0, SRC_WDOG);
        chk(onehot, 16'h1);
        wr(CONFIG_ADDR, {6'h0, RTC_XTAL_HIGH});
        repeat (2) @(posedge clk_sys);
        #1 chk(xopt, OPT_HIGH);
        // divider back at zero: cpu clock is the osc clock, pin period 2
        rst_dut(1'b0, SRC_EXT);
        chk(onehot, 16'h4);
        count(80);
        chk(cr, 16'h28);
        chk(period, 16'h2);
        rst_dut(1'b1, SRC_RC);
        rd(TUNE_ADDR, rv);
        chk(rv, {2'h0, TUNE_FACTORY});
        tally_and_finish;
    end
endmodule : clock_source_select_and_output_bench
`default_nettype wire
